// >>> hw/spectral_threshold_interrupt.sv
// spectral threshold window, persistence and interrupt flag with its registers
`include "spectral_threshold_map.svh"
module spectral_threshold_interrupt #(
	parameter int         NCH      = `NUM_CHANNELS,
	parameter int         PW       = `PERS_WIDTH,
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // arbitrary value
) (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 sclIn,
	input  wire logic                 sdaIn,
	output logic                      sdaOut,
	output logic                      sdaOe,
	input  wire logic                 spectralIrqEnable,
	input  wire logic [PW-1:0]        persistenceCount,
	input  wire logic                 resultValid,
	input  wire logic [NCH-1:0][15:0] channelResult,
	output logic                      spectralIrq
);
	logic [1:0]    rstSync_q;
	logic          rstn;
	reg_access_if  regBus ();

	logic [7:0]    lowHold_q, lowHold_d, highHold_q, highHold_d;
	logic [15:0]   lowThr_q, lowThr_d, highThr_q, highThr_d;
	logic [2:0]    chanSel_q, chanSel_d;
	logic [PW-1:0] persCnt_q, persCnt_d;
	logic          flag_q, flag_d;
	logic [NCH-1:0] chanOut;
	logic          selValid, outside, hit, clearFlag;
	logic [PW-1:0] persNext, persNeed;

	// async assert, release through two stages
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync_q <= 2'b00;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstn = rstSync_q[1];

	i2c_reg_slave #(.DEV_ADDR(DEV_ADDR)) serialPort (
		.clk   (clk),
		.rstn  (rstn),
		.sclIn (sclIn),
		.sdaIn (sdaIn),
		.sdaOe (sdaOe),
		.bus   (regBus.slave)
	);
	assign sdaOut = 1'b0; // open drain: only pulls low

	// per-channel window compare
	for (genvar i = 0; i < NCH; i++) begin : g_cmp
		assign chanOut[i] = (channelResult[i] < lowThr_q) || (channelResult[i] > highThr_q);
	end

	assign selValid  = 32'(chanSel_q) < NCH; // codes 5..7 compare nothing
	assign outside   = selValid && chanOut[chanSel_q[$clog2(NCH)-1:0]];
	assign persNext  = (&persCnt_q) ? persCnt_q : persCnt_q + {{(PW-1){1'b0}}, 1'b1};
	assign persNeed  = (persistenceCount == '0) ? {{(PW-1){1'b0}}, 1'b1} : persistenceCount;
	assign hit       = resultValid && outside && (persNext >= persNeed);
	assign clearFlag = regBus.wrEn && regBus.wrAddr == `STATUS_ADDR
		&& regBus.wrData[`SPECTRAL_FLAG_BIT];

	always_comb begin
		lowHold_d  = lowHold_q;
		highHold_d = highHold_q;
		lowThr_d   = lowThr_q;
		highThr_d  = highThr_q;
		chanSel_d  = chanSel_q;
		persCnt_d  = persCnt_q;
		flag_d     = flag_q;
		if (regBus.wrEn) begin
			unique case (regBus.wrAddr)
				`LOW_THR_LOW_ADDR:   lowHold_d  = regBus.wrData;
				`LOW_THR_HIGH_ADDR:  lowThr_d   = {regBus.wrData, lowHold_q};
				`HIGH_THR_LOW_ADDR:  highHold_d = regBus.wrData;
				`HIGH_THR_HIGH_ADDR: highThr_d  = {regBus.wrData, highHold_q};
				`CHAN_CFG_ADDR:      chanSel_d  = regBus.wrData[`CHAN_SEL_MSB:0];
				default: begin
				end
			endcase
		end
		if (resultValid && selValid) begin
			persCnt_d = outside ? persNext : '0;
		end
		if (clearFlag) begin
			flag_d = 1'b0;
		end
		if (hit && spectralIrqEnable) begin
			flag_d = 1'b1; // set beats a same-cycle clear
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lowHold_q  <= 8'h00;
			highHold_q <= 8'h00;
			lowThr_q   <= `THR_RESET;
			highThr_q  <= `THR_RESET;
			chanSel_q  <= `CHAN_SEL_RESET;
			persCnt_q  <= '0;
			flag_q     <= 1'b0;
		end else begin
			lowHold_q  <= lowHold_d;
			highHold_q <= highHold_d;
			lowThr_q   <= lowThr_d;
			highThr_q  <= highThr_d;
			chanSel_q  <= chanSel_d;
			persCnt_q  <= persCnt_d;
			flag_q     <= flag_d;
		end
	end

	// low-byte registers read back the held byte, not the active one
	always_comb begin
		unique case (regBus.rdAddr)
			`LOW_THR_LOW_ADDR:   regBus.rdData = lowHold_q;
			`LOW_THR_HIGH_ADDR:  regBus.rdData = lowThr_q[15:8];
			`HIGH_THR_LOW_ADDR:  regBus.rdData = highHold_q;
			`HIGH_THR_HIGH_ADDR: regBus.rdData = highThr_q[15:8];
			`CHAN_CFG_ADDR:      regBus.rdData = {5'h00, chanSel_q};
			`STATUS_ADDR:        regBus.rdData = {4'h0, flag_q, 3'h0};
			default:             regBus.rdData = 8'h00;
		endcase
	end

	assign spectralIrq = flag_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	low_thr_apply_a: assert property (
		regBus.wrEn && regBus.wrAddr == `LOW_THR_HIGH_ADDR
		|=> lowThr_q == {$past(regBus.wrData), $past(lowHold_q)})
		else $error("low threshold not formed from both bytes");
	high_thr_apply_a: assert property (
		regBus.wrEn && regBus.wrAddr == `HIGH_THR_HIGH_ADDR
		|=> highThr_q == {$past(regBus.wrData), $past(highHold_q)})
		else $error("high threshold not formed from both bytes");
	hold_latch_a: assert property (
		regBus.wrEn && regBus.wrAddr == `HIGH_THR_LOW_ADDR
		|=> highHold_q == $past(regBus.wrData) && $stable(highThr_q))
		else $error("high low byte not latched");
	low_only_a: assert property (
		regBus.wrEn && regBus.wrAddr == `LOW_THR_LOW_ADDR |=> $stable(lowThr_q))
		else $error("active low threshold changed on low byte write");
	chan_sel_a: assert property (
		regBus.wrEn && regBus.wrAddr == `CHAN_CFG_ADDR
		|=> chanSel_q == $past(regBus.wrData[2:0]))
		else $error("channel select not stored");
	pers_restart_a: assert property (
		resultValid && selValid && !outside |=> persCnt_q == '0)
		else $error("persistence count not restarted");
	flag_set_a: assert property (
		hit && spectralIrqEnable |=> flag_q && spectralIrq)
		else $error("met event did not set flag");
	flag_cause_a: assert property (
		$rose(flag_q) |-> $past(resultValid && outside && spectralIrqEnable))
		else $error("flag rose without out-of-window event");
	flag_keep_a: assert property (
		flag_q && !clearFlag |=> flag_q)
		else $error("flag lost without a one written");

	low_hold_a: assert property (
		regBus.wrEn && regBus.wrAddr == `LOW_THR_LOW_ADDR
		|=> lowHold_q == $past(regBus.wrData))
		else $error("low threshold low byte not latched");
	hold_keep_a: assert property (
		!(regBus.wrEn && regBus.wrAddr == `LOW_THR_LOW_ADDR)
		|=> $stable(lowHold_q))
		else $error("held low byte changed without a write");
	low_keep_a: assert property (
		!(regBus.wrEn && regBus.wrAddr == `LOW_THR_HIGH_ADDR)
		|=> $stable(lowThr_q))
		else $error("low threshold changed without high byte write");
	high_keep_a: assert property (
		!(regBus.wrEn && regBus.wrAddr == `HIGH_THR_HIGH_ADDR)
		|=> $stable(highThr_q))
		else $error("high threshold changed without high byte write");
	chan_keep_a: assert property (
		!(regBus.wrEn && regBus.wrAddr == `CHAN_CFG_ADDR)
		|=> $stable(chanSel_q))
		else $error("channel select changed without a write");
	sel_refused_a: assert property (
		resultValid && !selValid
		|=> $stable(persCnt_q) && !$rose(flag_q))
		else $error("refused select code took part in a compare");
	window_in_a: assert property (
		resultValid && selValid && channelResult[chanSel_q[$clog2(NCH)-1:0]] >= lowThr_q
		&& channelResult[chanSel_q[$clog2(NCH)-1:0]] <= highThr_q |=> persCnt_q == '0)
		else $error("in-window result did not restart persistence");
	window_out_a: assert property (
		resultValid && selValid && !(&persCnt_q)
		&& channelResult[chanSel_q[$clog2(NCH)-1:0]] > highThr_q |=> persCnt_q != '0)
		else $error("result above high threshold not counted");
	pers_count_a: assert property (
		resultValid && outside && !(&persCnt_q)
		|=> persCnt_q == $past(persCnt_q) + PW'(1))
		else $error("persistence count did not step by one");
	pers_saturate_a: assert property (
		resultValid && outside && (&persCnt_q)
		|=> &persCnt_q)
		else $error("persistence count wrapped");
	pers_idle_a: assert property (
		!resultValid
		|=> $stable(persCnt_q))
		else $error("persistence count moved without a result");
	flag_clear_a: assert property (
		flag_q && clearFlag && !(hit && spectralIrqEnable)
		|=> !flag_q)
		else $error("flag not cleared by a one written");
	flag_enable_a: assert property (
		!flag_q && !spectralIrqEnable
		|=> !flag_q)
		else $error("flag set while interrupt disabled");
	flag_quiet_a: assert property (
		!flag_q && !resultValid
		|=> !flag_q)
		else $error("flag set without a measurement");
	pers_need_a: assert property (
		!flag_q && persistenceCount > PW'(1) && persCnt_q == '0
		|=> !flag_q)
		else $error("flag set before persistence reached");
endmodule // spectral_threshold_interrupt

// >>> shared/spectral_threshold_map.svh
// register map, field positions, reset values and sizes for the spectral threshold block
`ifndef SPECTRAL_THRESHOLD_MAP_SVH
`define SPECTRAL_THRESHOLD_MAP_SVH

`define LOW_THR_LOW_ADDR   8'h84
`define LOW_THR_HIGH_ADDR  8'h85
`define HIGH_THR_LOW_ADDR  8'h86
`define HIGH_THR_HIGH_ADDR 8'h87
`define CHAN_CFG_ADDR      8'hB5
`define STATUS_ADDR        8'h93
`define CHAN_SEL_MSB       2
`define SPECTRAL_FLAG_BIT  3
`define THR_RESET          16'h0000
`define CHAN_SEL_RESET     3'h0
`define NUM_CHANNELS       5
`define PERS_WIDTH         4
`define DEV_ADDR_DEFAULT   7'h2A

`endif

// >>> shared/spectral_threshold_pkg.sv
// types shared by the spectral threshold design
package spectral_threshold_pkg;
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b000,
		BUS_ADDR  = 3'b001,
		BUS_AACK  = 3'b010,
		BUS_WRITE = 3'b011,
		BUS_WACK  = 3'b100,
		BUS_READ  = 3'b101,
		BUS_RACK  = 3'b110
	} bus_state_e;
	typedef logic [7:0] byte_t;
endpackage

// >>> shared/reg_access_if.sv
// register access carrier between the serial slave and the register file
interface reg_access_if;
	logic       wrEn;
	logic [7:0] wrAddr;
	logic [7:0] wrData;
	logic [7:0] rdAddr;
	logic [7:0] rdData;
	modport slave (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
	modport regs  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// >>> hw/i2c_reg_slave.sv
// two-wire serial slave giving byte access to the register file
`include "spectral_threshold_map.svh"
module i2c_reg_slave #(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // arbitrary value
) (
	input  wire logic     clk,
	input  wire logic     rstn,
	input  wire logic     sclIn,
	input  wire logic     sdaIn,
	output logic          sdaOe,
	reg_access_if.slave   bus
);
	spectral_threshold_pkg::bus_state_e state_q, state_d;
	spectral_threshold_pkg::byte_t      shift_q, shift_d, ptr_q, ptr_d;
	spectral_threshold_pkg::byte_t      wrAddr_q, wrAddr_d, wrData_q, wrData_d;
	logic [3:0] cnt_q, cnt_d;
	logic       sclPrev_q, sdaPrev_q, ptrSet_q, ptrSet_d, rw_q, rw_d;
	logic       sdaLow_q, sdaLow_d, wrEn_q, wrEn_d;
	logic       start, stop, rise, fall;

	assign start = sclIn && sdaPrev_q && !sdaIn;
	assign stop  = sclIn && !sdaPrev_q && sdaIn;
	assign rise  = !sclPrev_q && sclIn;
	assign fall  = sclPrev_q && !sclIn;

	always_comb begin
		state_d  = state_q;
		shift_d  = shift_q;
		ptr_d    = ptr_q;
		cnt_d    = cnt_q;
		ptrSet_d = ptrSet_q;
		rw_d     = rw_q;
		sdaLow_d = sdaLow_q;
		wrEn_d   = 1'b0;
		wrAddr_d = wrAddr_q;
		wrData_d = wrData_q;
		if (start) begin
			state_d  = spectral_threshold_pkg::BUS_ADDR;
			cnt_d    = 4'h0;
			ptrSet_d = 1'b0;
			sdaLow_d = 1'b0;
		end else if (stop) begin
			state_d  = spectral_threshold_pkg::BUS_IDLE;
			sdaLow_d = 1'b0;
		end else begin
			if (rise && state_q != spectral_threshold_pkg::BUS_READ) begin
				shift_d = {shift_q[6:0], sdaIn};
				cnt_d   = cnt_q + 4'h1;
			end else if (rise) begin
				cnt_d = cnt_q + 4'h1;
			end
			if (fall) begin
				unique case (state_q)
					spectral_threshold_pkg::BUS_IDLE: begin
					end
					spectral_threshold_pkg::BUS_ADDR: begin
						if (cnt_q == 4'h8) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								state_d  = spectral_threshold_pkg::BUS_AACK;
								sdaLow_d = 1'b1;
								rw_d     = shift_q[0];
							end else begin
								state_d = spectral_threshold_pkg::BUS_IDLE;
							end
						end
					end
					spectral_threshold_pkg::BUS_AACK, spectral_threshold_pkg::BUS_RACK: begin
						cnt_d = 4'h0;
						if (state_q == spectral_threshold_pkg::BUS_RACK && shift_q[0]) begin
							state_d  = spectral_threshold_pkg::BUS_IDLE; // master nack ends reads
							sdaLow_d = 1'b0;
						end else if (rw_q) begin
							state_d  = spectral_threshold_pkg::BUS_READ;
							shift_d  = bus.rdData;
							sdaLow_d = !bus.rdData[7];
						end else begin
							state_d  = spectral_threshold_pkg::BUS_WRITE;
							sdaLow_d = 1'b0;
						end
					end
					spectral_threshold_pkg::BUS_WRITE: begin
						if (cnt_q == 4'h8) begin
							state_d  = spectral_threshold_pkg::BUS_WACK;
							sdaLow_d = 1'b1;
							if (!ptrSet_q) begin
								ptr_d    = shift_q;
								ptrSet_d = 1'b1;
							end else begin
								wrEn_d   = 1'b1;
								wrAddr_d = ptr_q;
								wrData_d = shift_q;
								ptr_d    = ptr_q + 8'h01; // auto-increment lets one transfer hit both bytes
							end
						end
					end
					spectral_threshold_pkg::BUS_WACK: begin
						state_d  = spectral_threshold_pkg::BUS_WRITE;
						sdaLow_d = 1'b0;
						cnt_d    = 4'h0;
					end
					spectral_threshold_pkg::BUS_READ: begin
						if (cnt_q == 4'h8) begin
							state_d  = spectral_threshold_pkg::BUS_RACK;
							sdaLow_d = 1'b0;
							ptr_d    = ptr_q + 8'h01;
						end else begin
							sdaLow_d = !shift_q[6];
							shift_d  = {shift_q[6:0], 1'b0};
						end
					end
					default: state_d = spectral_threshold_pkg::BUS_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q   <= spectral_threshold_pkg::BUS_IDLE;
			shift_q   <= 8'h00;
			ptr_q     <= 8'h00;
			cnt_q     <= 4'h0;
			ptrSet_q  <= 1'b0;
			rw_q      <= 1'b0;
			sdaLow_q  <= 1'b0;
			wrEn_q    <= 1'b0;
			wrAddr_q  <= 8'h00;
			wrData_q  <= 8'h00;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			state_q   <= state_d;
			shift_q   <= shift_d;
			ptr_q     <= ptr_d;
			cnt_q     <= cnt_d;
			ptrSet_q  <= ptrSet_d;
			rw_q      <= rw_d;
			sdaLow_q  <= sdaLow_d;
			wrEn_q    <= wrEn_d;
			wrAddr_q  <= wrAddr_d;
			wrData_q  <= wrData_d;
			sclPrev_q <= sclIn;
			sdaPrev_q <= sdaIn;
		end
	end

	assign sdaOe      = sdaLow_q;
	assign bus.wrEn   = wrEn_q;
	assign bus.wrAddr = wrAddr_q;
	assign bus.wrData = wrData_q;
	assign bus.rdAddr = ptr_q;
endmodule // i2c_reg_slave

// >>> tb/i2c_host_model.sv
// two-wire host model driving the serial port of the block
module i2c_host_model (
	input  wire logic clk,
	input  wire logic sdaLine,
	output logic      scl,
	output logic      sdaLow
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// four clocks a phase, above the two-clock minimum
	task automatic tick();
		repeat (4) @(posedge clk);
	endtask
	// also serves as repeated start
	task automatic start();
		@(posedge clk);
		sdaLow <= 1'b0;
		tick();
		scl <= 1'b1;
		tick();
		sdaLow <= 1'b1;
		tick();
		scl <= 1'b0;
		tick();
	endtask
	task automatic stop();
		@(posedge clk);
		sdaLow <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		sdaLow <= 1'b0;
		tick();
	endtask
	// data moves one clock after scl falls, never with it
	task automatic clkBit(input logic v, output logic s);
		@(posedge clk);
		sdaLow <= !v;
		tick();
		scl <= 1'b1;
		tick();
		s = sdaLine;
		scl <= 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clkBit(b[i], s);
		clkBit(1'b1, s);
		ack = !s;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clkBit(1'b1, s);
			b[i] = s;
		end
		clkBit(nack, s);
	endtask
endmodule // i2c_host_model

// >>> tb/spectral_threshold_interrupt_tb.sv
// self-checking bench for the spectral threshold block
`include "spectral_threshold_map.svh"
module spectral_threshold_interrupt_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic             clk;
	logic             nrst;
	logic             ien;
	logic             valid;
	logic [3:0]       pers;
	logic [4:0][15:0] chRes;
	logic             irq;
	logic             scl;
	logic             sdaLow;
	logic             sdaOe;
	logic             sdaOut;
	wire logic        sdaLine;
	int               num_errors;
	int               checks_done;
	logic [7:0]       rd;
	logic             ack;
	logic [7:0]       regAddr [6] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'hB5, 8'h93};
	// pull-up: low when the host pulls or the device drives its low level
	assign sdaLine = (sdaLow || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;
	always #50 clk = !clk;
	spectral_threshold_interrupt spectral_threshold_interrupt_i (
		.clk(clk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.spectralIrqEnable(ien), .persistenceCount(pers), .resultValid(valid),
		.channelResult(chRes), .spectralIrq(irq)
	);
	i2c_host_model i2c_host_model_i (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrRegs(input logic [7:0] addr, input logic [31:0] d, input int n);
		i2c_host_model_i.start();
		i2c_host_model_i.wbyte({`DEV_ADDR_DEFAULT, 1'b0}, ack);
		check("address ack", ack, 1'b1);
		i2c_host_model_i.wbyte(addr, ack);
		for (int i = 0; i < n; i++) i2c_host_model_i.wbyte(d[8*i+:8], ack);
		i2c_host_model_i.stop();
	endtask
	task automatic rdReg(input logic [7:0] addr, output logic [7:0] d);
		wrRegs(addr, 32'h0, 0);
		i2c_host_model_i.start();
		i2c_host_model_i.wbyte({`DEV_ADDR_DEFAULT, 1'b1}, ack);
		i2c_host_model_i.rbyte(1'b1, d);
		i2c_host_model_i.stop();
	endtask
	// unselected channels sit inside the window
	task automatic meas(input int ch, input logic [15:0] v, input int n, input logic en);
		logic [4:0][15:0] r;
		r = {5{16'h0150}};
		r[ch] = v;
		@(posedge clk);
		ien <= en;
		chRes <= r;
		valid <= 1'b1;
		repeat (n) @(posedge clk);
		valid <= 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		final_report();
	end
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		ien = 1'b0;
		valid = 1'b0;
		pers = 4'h2;
		chRes = '0;
		num_errors = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (regAddr[i]) begin
			rdReg(regAddr[i], rd);
			check("reset value", rd, 8'h00);
		end
		$display("test reset values done");
		wrRegs(8'h84, 32'h0200_0100, 4);
		rdReg(8'h85, rd);
		check("low thr high byte", rd, 8'h01);
		rdReg(8'h87, rd);
		check("high thr high byte", rd, 8'h02);
		$display("test thresholds done");
		meas(0, 16'h00FF, 1, 1'b1);
		meas(0, 16'h0100, 1, 1'b1);
		meas(0, 16'h0201, 1, 1'b1);
		check("irq after restart", irq, 1'b0);
		meas(0, 16'h0201, 1, 1'b1);
		check("irq after persistence", irq, 1'b1);
		rdReg(8'h93, rd);
		check("status flag", rd, 8'h08);
		wrRegs(8'h93, 32'h00, 1);
		check("irq after zero write", irq, 1'b1);
		wrRegs(8'h93, {24'h0, rd}, 1);
		check("irq after write back", irq, 1'b0);
		$display("test persistence done");
		meas(0, 16'h0300, 2, 1'b0);
		check("irq disabled", irq, 1'b0);
		$display("test enable done");
		wrRegs(8'h84, 32'hFF, 1);
		rdReg(8'h84, rd);
		check("held low byte", rd, 8'hFF);
		meas(0, 16'h0150, 2, 1'b1);
		check("low byte alone", irq, 1'b0);
		wrRegs(8'h85, 32'h00, 1);
		meas(0, 16'h00FF, 2, 1'b1);
		check("on new low edge", irq, 1'b0);
		meas(0, 16'h00FE, 2, 1'b1);
		check("below new low", irq, 1'b1);
		wrRegs(8'h93, 32'h08, 1);
		$display("test byte latch done");
		wrRegs(8'hB5, 32'h03, 1);
		meas(0, 16'hFFFF, 2, 1'b1);
		check("unselected channel", irq, 1'b0);
		meas(3, 16'hFFFF, 2, 1'b1);
		check("selected channel", irq, 1'b1);
		rdReg(8'hB5, rd);
		check("channel select", rd, 8'h03);
		$display("test channel select done");
		wrRegs(8'h93, 32'h08, 1);
		wrRegs(8'hB5, 32'h05, 1);
		meas(1, 16'hFFFF, 2, 1'b1);
		check("refused select", irq, 1'b0);
		rdReg(8'hB5, rd);
		check("select code five", rd, 8'h05);
		wrRegs(8'hB5, 32'h00, 1);
		meas(0, 16'h0150, 1, 1'b1);
		@(posedge clk);
		pers <= 4'h0;
		meas(0, 16'hFFFF, 1, 1'b1);
		check("persistence zero", irq, 1'b1);
		$display("test refused codes done");
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		check("irq in reset", irq, 1'b0);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		rdReg(8'hB5, rd);
		check("select after reset", rd, 8'h00);
		rdReg(8'h87, rd);
		check("high thr after reset", rd, 8'h00);
		$display("test mid-run reset done");
		final_report();
	end
endmodule // spectral_threshold_interrupt_tb
